// *** shared/ccs_pkg.sv ***
// Purpose: Constants and types for the comparator control and status block
// Assumes: 8-bit special function register port, single system clock
// Notes:   Register page and address decode values live here
package ccs_pkg;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   localparam logic [7:0] CCS_CTRL_ADDR = 8'h9A;
   localparam logic [7:0] CCS_CTRL_PAGE = 8'h00;
   localparam logic [7:0] CCS_CTRL_RESET = 8'h00;
   localparam logic [7:0] CCS_MODE_ADDR = 8'h9D;
   localparam logic [7:0] CCS_MODE_PAGE = 8'h00;
   localparam logic [1:0] CCS_MODE_RESET = 2'h0;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CCS_BIT_EN = 7;
   localparam int CCS_BIT_OUT = 6;
   localparam int CCS_BIT_RISE = 5;
   localparam int CCS_BIT_FALL = 4;
   localparam int CCS_POS_HYP_LSB = 2;
   localparam int CCS_POS_HYN_LSB = 0;
   localparam int CCS_IRQ_EN_BIT = 4;

   // Edge detector states
   typedef enum logic [1:0] {
      CCS_IDLE,
      CCS_SETTLE,
      CCS_ARMED
   } ccs_state_t;

endpackage : ccs_pkg

// *** design/ccs_sync.sv ***
// Purpose: Two-stage synchroniser for the comparator result
// Assumes: Async input from the analog core
// Notes:   First stage is read only by the second
`timescale 1ns/1ps
module ccs_sync (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic async_i,
   output logic sync_o
);

   logic meta_reg;
   logic meta_next;
   logic sync_reg;
   logic sync_next;

   // Next values
   always_comb begin
      meta_next = ce_i ? async_i : meta_reg;
      sync_next = ce_i ? meta_reg : sync_reg;
   end

   // Two flops
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;

endmodule : ccs_sync

// *** design/ccs_comparator_control_status.sv ***
// Purpose: Control and status wrapper for an analog comparator
// Assumes: Register access by address, page, write and read strobes
// Notes:   Only the clock synchronised pin output is built here; the path select is just registered
`timescale 1ns/1ps

// Summary of operation
// - Result readable, usable as interrupt, routable to a pin
// - Pin output clock synchronised only; async/sync select input is just registered out on pin_sel_sync_o
// - Disabled comparator drives pin output low and is powered down
// - Software response mode setting trades speed for supply current
// - Interrupt request on rising and falling output transitions
// - Rising transition sets flag at control bit 5
// - Falling transition sets flag at control bit 4
// - Flags sticky; only reset or software writing zero clears them
// - Bit 6 read-only live comparator result
// - Bit 7 is comparator enable
// - Bits 3:2 positive hysteresis select, forwarded to analog core
// - Bits 1:0 negative hysteresis select, forwarded to analog core
// - Control register at address 0x9A page 0x00, resets to zero
// - External interrupt enable bit 4 gates comparator interrupt
module ccs_comparator_control_status
   import ccs_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_page_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] irq_enable_reg_i,
   input wire logic cmp_async_i,
   input wire logic pin_sync_sel_i,
   output logic [7:0] reg_rdata_o,
   output logic comparator_power_o,
   output logic [1:0] positive_hysteresis_select_o,
   output logic [1:0] negative_hysteresis_select_o,
   output logic [1:0] response_mode_o,
   output logic irq_o,
   output logic pin_sync_o,
   output logic pin_sel_sync_o
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic cmp_sync;
   logic en_reg;
   logic en_next;
   logic rise_reg;
   logic rise_next;
   logic fall_reg;
   logic fall_next;
   logic [1:0] hyp_reg;
   logic [1:0] hyp_next;
   logic [1:0] hyn_reg;
   logic [1:0] hyn_next;
   logic [1:0] mode_reg;
   logic [1:0] mode_next;
   logic prev_reg;
   logic prev_next;
   logic arm_reg;
   logic arm_next;
   ccs_state_t st_reg;
   ccs_state_t st_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic irq_reg;
   logic irq_next;
   logic pin_reg;
   logic pin_next;
   logic sel_reg;
   logic sel_next;
   logic ctrl_wr;
   logic mode_wr;
   logic rise_ev;
   logic fall_ev;

   // Register decode function
   function automatic logic hit(input logic [7:0] a, input logic [7:0] p,
                                input logic [7:0] ra, input logic [7:0] rp);
      hit = (a == ra) && (p == rp);
   endfunction : hit

   // ----------------------------------------
   // Synchroniser
   // ----------------------------------------
   ccs_sync ccs_sync_inst (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .async_i(cmp_async_i),
      .sync_o(cmp_sync)
   );

   // ----------------------------------------
   // Control and edge logic
   // ----------------------------------------

   // Decode and edge events
   always_comb begin
      ctrl_wr = reg_wr_i && hit(reg_addr_i, reg_page_i, CCS_CTRL_ADDR, CCS_CTRL_PAGE);
      mode_wr = reg_wr_i && hit(reg_addr_i, reg_page_i, CCS_MODE_ADDR, CCS_MODE_PAGE);
      rise_ev = (st_reg == CCS_ARMED) && arm_reg && cmp_sync && !prev_reg;
      fall_ev = (st_reg == CCS_ARMED) && arm_reg && !cmp_sync && prev_reg;
   end

   // Next state of control fields and flags
   always_comb begin
      en_next = en_reg;
      hyp_next = hyp_reg;
      hyn_next = hyn_reg;
      mode_next = mode_reg;
      rise_next = rise_reg;
      fall_next = fall_reg;
      if (ctrl_wr) begin
         en_next = reg_wdata_i[CCS_BIT_EN];
         hyp_next = reg_wdata_i[CCS_POS_HYP_LSB +: 2];
         hyn_next = reg_wdata_i[CCS_POS_HYN_LSB +: 2];
         rise_next = reg_wdata_i[CCS_BIT_RISE];
         fall_next = reg_wdata_i[CCS_BIT_FALL];
      end
      if (mode_wr) begin
         mode_next = reg_wdata_i[1:0];
      end
      // Hardware set wins over software clear
      if (rise_ev) begin
         rise_next = 1'b1;
      end
      if (fall_ev) begin
         fall_next = 1'b1;
      end
   end

   // Edge detector arming sequence
   // Extra armed cycle lets prev catch up with the settled synchroniser
   always_comb begin
      prev_next = cmp_sync;
      arm_next = (st_reg == CCS_ARMED) && en_reg;
      case (st_reg)
         CCS_IDLE: st_next = en_reg ? CCS_SETTLE : CCS_IDLE;
         CCS_SETTLE: st_next = en_reg ? CCS_ARMED : CCS_IDLE;
         CCS_ARMED: st_next = en_reg ? CCS_ARMED : CCS_IDLE;
         default: st_next = CCS_IDLE;
      endcase
   end

   // Outputs and read data
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_i && hit(reg_addr_i, reg_page_i, CCS_CTRL_ADDR, CCS_CTRL_PAGE)) begin
         rdata_next = {en_reg, cmp_sync, rise_reg, fall_reg, hyp_reg, hyn_reg};
      end else if (reg_rd_i && hit(reg_addr_i, reg_page_i, CCS_MODE_ADDR, CCS_MODE_PAGE)) begin
         rdata_next = {6'h00, mode_reg};
      end
      irq_next = irq_enable_reg_i[CCS_IRQ_EN_BIT] && (rise_next || fall_next);
      pin_next = en_next && cmp_sync;
      sel_next = pin_sync_sel_i;
   end

   // State registers
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         en_reg <= CCS_CTRL_RESET[CCS_BIT_EN];
         rise_reg <= CCS_CTRL_RESET[CCS_BIT_RISE];
         fall_reg <= CCS_CTRL_RESET[CCS_BIT_FALL];
         hyp_reg <= CCS_CTRL_RESET[3:2];
         hyn_reg <= CCS_CTRL_RESET[1:0];
         mode_reg <= CCS_MODE_RESET;
         prev_reg <= 1'b0;
         arm_reg <= 1'b0;
         st_reg <= CCS_IDLE;
         rdata_reg <= 8'h00;
         irq_reg <= 1'b0;
         pin_reg <= 1'b0;
         sel_reg <= 1'b0;
      end else if (ce_i) begin
         en_reg <= en_next;
         rise_reg <= rise_next;
         fall_reg <= fall_next;
         hyp_reg <= hyp_next;
         hyn_reg <= hyn_next;
         mode_reg <= mode_next;
         prev_reg <= prev_next;
         arm_reg <= arm_next;
         st_reg <= st_next;
         rdata_reg <= rdata_next;
         irq_reg <= irq_next;
         pin_reg <= pin_next;
         sel_reg <= sel_next;
      end
   end

   // ----------------------------------------
   // Output drive
   // ----------------------------------------
   assign reg_rdata_o = rdata_reg;
   assign comparator_power_o = en_reg;
   assign positive_hysteresis_select_o = hyp_reg;
   assign negative_hysteresis_select_o = hyn_reg;
   assign response_mode_o = mode_reg;
   assign irq_o = irq_reg;
   assign pin_sync_o = pin_reg;
   assign pin_sel_sync_o = sel_reg;

endmodule : ccs_comparator_control_status

// *** testbench/ccs_analog_model.sv ***
// Purpose: Analog comparator core model
// Assumes: Input level chosen by the bench
// Notes:   An unpowered core reads low
`timescale 1ns/1ps
module ccs_analog_model (
   input wire logic power_i,
   input wire logic level_i,
   output logic result_o
);
   // Result gated by the core supply
   assign result_o = power_i & level_i;
endmodule : ccs_analog_model

// *** testbench/ccs_chk_assertions.sv ***
// Purpose: Port checker for the comparator control block
// Assumes: Sees the top module ports only
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module ccs_chk
   import ccs_pkg::*;
(
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_page_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] irq_enable_reg_i,
   input wire logic cmp_async_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic comparator_power_o,
   input wire logic [1:0] positive_hysteresis_select_o,
   input wire logic [1:0] negative_hysteresis_select_o,
   input wire logic irq_o,
   input wire logic pin_sync_o,
   input wire logic pin_sync_sel_i,
   input wire logic pin_sel_sync_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (srst_i);
   // Control register hit
   wire ctl_hit = ce_i && reg_addr_i == CCS_CTRL_ADDR && reg_page_i == CCS_CTRL_PAGE;
   sequence s_ctl_wr;
      ctl_hit && reg_wr_i;
   endsequence
   sequence s_settled;
      (comparator_power_o && ce_i && !reg_wr_i && irq_enable_reg_i[4])[*6];
   endsequence
   a_pin_low_off: assert property (!comparator_power_o |-> !pin_sync_o)
      else $error("pin high while off");
   a_enable_write: assert property (s_ctl_wr |=> comparator_power_o == $past(reg_wdata_i[7]))
      else $error("enable not taken");
   a_hyst_write: assert property (s_ctl_wr |=> {positive_hysteresis_select_o, negative_hysteresis_select_o} == $past(reg_wdata_i[3:0]))
      else $error("hysteresis not forwarded");
   a_read_ctl: assert property (ctl_hit && reg_rd_i && !reg_wr_i |=> reg_rdata_o[7] == comparator_power_o
      && reg_rdata_o[3:0] == {positive_hysteresis_select_o, negative_hysteresis_select_o}) else $error("bad read");
   a_unmapped_hold: assert property (ce_i && reg_rd_i && reg_addr_i != CCS_CTRL_ADDR
      && reg_addr_i != CCS_MODE_ADDR |=> $stable(reg_rdata_o)) else $error("unmapped read changed data");
   a_irq_gate: assert property (irq_o |-> irq_enable_reg_i[4] || $past(irq_enable_reg_i[4]))
      else $error("irq while masked");
   a_irq_sticky: assert property ($fell(irq_o) |-> $past(reg_wr_i) || !$past(irq_enable_reg_i[4])
      || !irq_enable_reg_i[4]) else $error("flag cleared by hardware");
   a_rise_irq: assert property ($rose(cmp_async_i) && $past(comparator_power_o, 4) ##0 s_settled |-> irq_o)
      else $error("rise missed");
   a_fall_irq: assert property ($fell(cmp_async_i) && $past(comparator_power_o, 4) ##0 s_settled |-> irq_o)
      else $error("fall missed");
   a_pin_sync: assert property ((comparator_power_o && ce_i && $stable(cmp_async_i))[*6] |-> pin_sync_o == cmp_async_i)
      else $error("pin not following");
   a_sel_follow: assert property (ce_i |=> pin_sel_sync_o == $past(pin_sync_sel_i))
      else $error("path select not registered");
endmodule : ccs_chk
bind ccs_comparator_control_status ccs_chk ccs_chk_inst (.*);

// *** testbench/ccs_comparator_control_status_bench.sv ***
// Purpose: Self-checking bench for the comparator control block
// Assumes: Inputs driven at the falling edge
// Notes:   Xorshift stimulus from a fixed seed
`timescale 1ns/1ps
module ccs_comparator_control_status_bench;
   import ccs_pkg::*;
   logic clock_i = 0, srst_i = 1, ce_i = 1, reg_wr_i = 0, reg_rd_i = 0, level = 0, sel = 0;
   logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, ien = 8'h00, rdata, v;
   logic [15:0] seed = 16'h8FFC;
   logic cmp, pwr, irq, psync;
   logic [1:0] hp, hn, md;
   int error_cnt = 0, cmp_count = 0, cycles = 0;
   // Clock and design
   always #20 clock_i = ~clock_i;
   ccs_comparator_control_status ccs_comparator_control_status_inst (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
      .reg_addr_i(addr), .reg_page_i(page), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(wdata),
      .irq_enable_reg_i(ien), .cmp_async_i(cmp), .pin_sync_sel_i(sel), .reg_rdata_o(rdata), .comparator_power_o(pwr),
      .positive_hysteresis_select_o(hp), .negative_hysteresis_select_o(hn), .response_mode_o(md), .irq_o(irq),
      .pin_sync_o(psync), .pin_sel_sync_o());
   ccs_analog_model ccs_analog_model_inst (.power_i(pwr), .level_i(level), .result_o(cmp));
   // Hang guard
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         error_cnt++;
         conclude();
      end
   end
   function automatic logic [15:0] xs(input logic [15:0] s);
      s = s ^ (s << 7);
      s = s ^ (s >> 9);
      return s ^ (s << 8);
   endfunction : xs
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One register access, write or read
   task automatic acc(input logic [7:0] a, input logic [7:0] p, input logic w, input logic [7:0] d);
      @(negedge clock_i);
      addr = a;
      page = p;
      wdata = d;
      reg_wr_i = w;
      reg_rd_i = !w;
      @(negedge clock_i);
      reg_wr_i = 0;
      reg_rd_i = 0;
   endtask : acc
   task automatic idle(input int n);
      repeat (n) @(negedge clock_i);
   endtask : idle
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // Main sequence
   initial begin
      repeat (16) @(negedge clock_i);
      srst_i = 0;
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, CCS_CTRL_RESET);
      acc(CCS_MODE_ADDR, CCS_MODE_PAGE, 0, 8'h00);
      chk(rdata, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         v = seed[7:0] & 8'hCF;
         level = seed[8];
         sel = seed[9];
         idle(4);
         acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, v);
         idle(4);
         acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
         chk(rdata, {v[7], v[7] & level, 2'h0, v[3:0]});
         chk({4'h0, hp, hn}, {4'h0, v[3:0]});
         chk({7'h00, psync}, {7'h00, v[7] & level});
         acc(CCS_MODE_ADDR, CCS_MODE_PAGE, 1, seed[15:8]);
         chk({6'h00, md}, {6'h00, seed[9:8]});
      end
      $display("random write test done");
      level = 0;
      ien = 8'h10;
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h80);
      idle(4);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h80);
      level = 1;
      idle(6);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, 8'hE0);
      chk({7'h00, irq}, 8'h01);
      level = 0;
      idle(6);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, 8'hB0);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h80);
      chk({7'h00, irq}, 8'h00);
      ien = 8'hEF;
      level = 1;
      idle(6);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, psync}, 8'h01);
      $display("edge test done");
      acc(8'h9B, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, 8'hB0);
      acc(CCS_CTRL_ADDR, 8'h0C, 1, 8'h00);
      ce_i = 0;
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h00);
      ce_i = 1;
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, 8'hE0);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h00);
      chk({7'h00, psync}, 8'h00);
      $display("refusal test done");
      // Enable with the input already high must not raise a flag
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h80);
      idle(6);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, 8'hC0);
      // Falling edge sets its flag on the same clock edge as a clearing write, and the set wins
      level = 0;
      idle(1);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 1, 8'h80);
      acc(CCS_CTRL_ADDR, CCS_CTRL_PAGE, 0, 8'h00);
      chk(rdata, 8'h90);
      $display("corner test done");
      conclude();
   end
endmodule : ccs_comparator_control_status_bench
